// ### src/xmbi_defines.vh
// Constants for the external memory bus interface.
// Assumes inclusion by bare name from the design files.
`ifndef XMBI_DEFINES_VH
`define XMBI_DEFINES_VH

// =============================================
// Bus cycle phases
`define XMBI_PH_IDLE   3'h0
`define XMBI_PH_ADDR   3'h1
`define XMBI_PH_LATCH  3'h2
`define XMBI_PH_DATA   3'h3
`define XMBI_PH_END    3'h4
`define XMBI_PH_VEC_HI 3'h5
`define XMBI_PH_VEC_LO 3'h6

// =============================================
// Start vector locations and widths
`define XMBI_VEC_ADDR_HI 16'h0000
`define XMBI_VEC_ADDR_LO 16'h0001
`define XMBI_ADDR_W      16
`define XMBI_DATA_W      8
`define XMBI_DS_CYCLES   2'h2

`endif

// ### src/xmbi_sync2.v
// Two-flop synchroniser for a vector of pin inputs.
// Assumes the input is asynchronous to sys_clk_i.
`default_nettype none

module xmbi_sync2 #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         sys_clk_i,
	input  wire         sys_rst_i,
	// Data
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

`default_nettype wire

// ### src/xmbi_core.v
// External memory bus master: multiplexed address/data with strobes.
// Assumes one 40 MHz clock; core requests arrive on the same clock.
// Assumes the external memory holds read data a few cycles past the data strobe.
`include "xmbi_defines.vh"
`default_nettype none

// Functional notes
// - Address strobe pulses low at cycle start.
// - Address, direction, space valid at strobe rise.
// - Software float puts all bus pins high-Z.
// - Data strobe times every external data transfer.
// - Write data valid by data strobe fall.
// - On-chip accesses keep data strobe high.
// - Direction low for external writes only.
// - After reset fetch start vector 00h/01h.
// - Two 64K spaces chosen by space select.
module xmbi_core #(
	parameter AW = `XMBI_ADDR_W,
	parameter DW = `XMBI_DATA_W
) (
	// Clock and reset
	input  wire          sys_clk_i,
	input  wire          sys_rst_i,
	// Core request side
	input  wire          req_valid_i,
	output wire          req_ready_o,
	input  wire          req_write_i,
	input  wire          req_program_i,
	input  wire          req_onchip_i,
	input  wire [AW-1:0] req_addr_i,
	input  wire [DW-1:0] req_wdata_i,
	output reg           rsp_valid_o,
	output reg  [DW-1:0] rsp_rdata_o,
	// Start vector
	output reg           vec_valid_o,
	output reg  [AW-1:0] vec_addr_o,
	// Bus float control
	input  wire          bus_float_i,
	// Bus pins
	output reg           addr_latch_strobe_n_o,
	output wire          addr_latch_strobe_n_oe_o,
	output reg           xfer_timing_strobe_n_o,
	output wire          xfer_timing_strobe_n_oe_o,
	output reg           read_write_o,
	output wire          read_write_oe_o,
	output reg           prog_space_o,
	output wire          prog_space_oe_o,
	output reg  [DW-1:0] muxed_addr_data_port_o,
	output reg           muxed_addr_data_port_oe_o,
	input  wire [DW-1:0] muxed_addr_data_port_i,
	output reg  [DW-1:0] high_addr_port_o,
	output wire          high_addr_port_oe_o
);
	// =============================================
	// State
	reg [2:0]    ph_q;
	reg [2:0]    ph_d;
	reg [2:0]    ret_q;
	reg [1:0]    cnt_q;
	reg          wr_q;
	reg          onchip_q;
	reg          vec_hi_q;
	reg [DW-1:0] vec_byte_q;
	reg [DW-1:0] wdata_q;
	reg [AW-1:0] addr_q;
	wire [DW-1:0] pin_data;

	// =============================================
	// Read data synchroniser
	// The port input passes two flops, so read data is taken one cycle after the
	// strobe rises, from the pin value sampled while the strobe was still low.
	xmbi_sync2 #(
		.W (DW)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (muxed_addr_data_port_i),
		.sync_o    (pin_data)
	);

	// =============================================
	// Output enables
	// common float
	assign addr_latch_strobe_n_oe_o   = ~bus_float_i;
	assign xfer_timing_strobe_n_oe_o  = ~bus_float_i;
	assign read_write_oe_o            = ~bus_float_i;
	assign prog_space_oe_o            = ~bus_float_i;
	assign high_addr_port_oe_o        = ~bus_float_i;

	// Requests wait for the start vector and for a driven bus.
	assign req_ready_o = (ph_q == `XMBI_PH_IDLE) && vec_valid_o && !bus_float_i;

	// =============================================
	// Phase sequencing
	always @* begin
		ph_d = ph_q;
		case (ph_q)
			`XMBI_PH_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					ph_d = `XMBI_PH_ADDR;
				end
			end
			`XMBI_PH_ADDR:   ph_d = `XMBI_PH_LATCH;
			`XMBI_PH_LATCH:  ph_d = `XMBI_PH_DATA;
			`XMBI_PH_DATA: begin
				if (cnt_q == 2'h0) begin
					ph_d = `XMBI_PH_END;
				end
			end
			`XMBI_PH_END:    ph_d = ret_q;
			`XMBI_PH_VEC_HI: ph_d = bus_float_i ? `XMBI_PH_VEC_HI : `XMBI_PH_ADDR;
			`XMBI_PH_VEC_LO: ph_d = `XMBI_PH_ADDR;
			default:         ph_d = `XMBI_PH_IDLE;
		endcase
	end

	// =============================================
	// Bus cycle registers
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ph_q                      <= `XMBI_PH_VEC_HI;
			ret_q                     <= `XMBI_PH_VEC_LO;
			cnt_q                     <= 2'h0;
			wr_q                      <= 1'b0;
			onchip_q                  <= 1'b0;
			vec_hi_q                  <= 1'b1;
			vec_byte_q                <= {DW{1'b0}};
			wdata_q                   <= {DW{1'b0}};
			addr_q                    <= `XMBI_VEC_ADDR_HI;
			rsp_valid_o               <= 1'b0;
			rsp_rdata_o               <= {DW{1'b0}};
			vec_valid_o               <= 1'b0;
			vec_addr_o                <= {AW{1'b0}};
			addr_latch_strobe_n_o     <= 1'b1;
			xfer_timing_strobe_n_o    <= 1'b1;
			read_write_o              <= 1'b1;
			prog_space_o              <= 1'b1;
			muxed_addr_data_port_o    <= {DW{1'b0}};
			muxed_addr_data_port_oe_o <= 1'b0;
			high_addr_port_o          <= {DW{1'b0}};
		end else begin
			ph_q        <= ph_d;
			rsp_valid_o <= 1'b0;
			case (ph_q)
				`XMBI_PH_IDLE: begin
					if (req_valid_i && req_ready_o) begin
						addr_q   <= req_addr_i;
						wr_q     <= req_write_i;
						onchip_q <= req_onchip_i;
						wdata_q  <= req_wdata_i;
						prog_space_o <= req_program_i;
						ret_q        <= `XMBI_PH_IDLE;
					end
				end
				// Both vector bytes run as ordinary reads; the return phase chains them.
				`XMBI_PH_VEC_HI, `XMBI_PH_VEC_LO: begin
					wr_q         <= 1'b0;
					onchip_q     <= 1'b0;
					prog_space_o <= 1'b1;
					addr_q       <= vec_hi_q ? `XMBI_VEC_ADDR_HI : `XMBI_VEC_ADDR_LO;
					ret_q        <= vec_hi_q ? `XMBI_PH_VEC_LO : `XMBI_PH_IDLE;
				end
				`XMBI_PH_ADDR: begin
					addr_latch_strobe_n_o     <= 1'b0;
					muxed_addr_data_port_o    <= addr_q[DW-1:0];
					muxed_addr_data_port_oe_o <= !bus_float_i;
					high_addr_port_o          <= addr_q[AW-1:DW];
					read_write_o              <= !(wr_q && !onchip_q);
				end
				`XMBI_PH_LATCH: begin
					addr_latch_strobe_n_o     <= 1'b1;
					// External writes keep the port driven; reads and on-chip writes release it.
					// data before strobe
					muxed_addr_data_port_o    <= wr_q ? wdata_q : {DW{1'b0}};
					muxed_addr_data_port_oe_o <= wr_q && !onchip_q && !bus_float_i;
					cnt_q                     <= `XMBI_DS_CYCLES;
				end
				`XMBI_PH_DATA: begin
					xfer_timing_strobe_n_o <= onchip_q || (cnt_q == 2'h0);
					if (cnt_q != 2'h0) begin
						cnt_q <= cnt_q - 2'h1;
					end
					if (bus_float_i) begin
						muxed_addr_data_port_oe_o <= 1'b0;
					end
				end
				`XMBI_PH_END: begin
					xfer_timing_strobe_n_o    <= 1'b1;
					muxed_addr_data_port_oe_o <= 1'b0;
					read_write_o              <= 1'b1;
					// The return phase marks the high vector half; vec_valid_o tells the low half from a request response.
					if (ret_q == `XMBI_PH_VEC_LO) begin
						vec_byte_q <= pin_data;
						vec_hi_q   <= 1'b0;
					end else if (!vec_valid_o) begin
						vec_addr_o  <= {vec_byte_q, pin_data};
						vec_valid_o <= 1'b1;
					end else begin
						rsp_valid_o <= 1'b1;
						rsp_rdata_o <= wr_q ? wdata_q : pin_data;
					end
				end
				default: begin
					addr_latch_strobe_n_o <= 1'b1;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// ### tb/xmbi_core_asserts.sv
// Checker for the pin behaviour of the bus master.
// Assumes it is bound onto xmbi_core.
`default_nettype none
module xmbi_core_asserts (
	input wire logic        sys_clk_i, sys_rst_i, req_valid_i, req_ready_o, req_write_i, req_onchip_i,
	input wire logic        req_program_i, bus_float_i, addr_latch_strobe_n_o, addr_latch_strobe_n_oe_o,
	input wire logic        xfer_timing_strobe_n_o, xfer_timing_strobe_n_oe_o, read_write_o, read_write_oe_o,
	input wire logic        prog_space_o, high_addr_port_oe_o, muxed_addr_data_port_oe_o,
	input wire logic [15:0] req_addr_i,
	input wire logic [7:0]  muxed_addr_data_port_o, high_addr_port_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire acc = req_valid_i & req_ready_o;
	a_as_pulse: assert property ($fell(addr_latch_strobe_n_o) |=> addr_latch_strobe_n_o)
		else $error("address strobe low too long");
	a_latch_stable: assert property ($rose(addr_latch_strobe_n_o) |->
		$stable(high_addr_port_o) && $stable(read_write_o) && $stable(prog_space_o)) else $error("address moved");
	a_float_oe: assert property (bus_float_i |-> !(addr_latch_strobe_n_oe_o | xfer_timing_strobe_n_oe_o
		| read_write_oe_o | high_addr_port_oe_o)) else $error("pin driven while floated");
	a_ds_two: assert property ($fell(xfer_timing_strobe_n_o) |=> !xfer_timing_strobe_n_o ##1 xfer_timing_strobe_n_o)
		else $error("data strobe width");
	a_wdata_ds: assert property ($fell(xfer_timing_strobe_n_o) && !read_write_o |->
		muxed_addr_data_port_oe_o && $stable(muxed_addr_data_port_o)) else $error("write data late");
	a_onchip_ds: assert property (acc && req_onchip_i |=> xfer_timing_strobe_n_o [*6])
		else $error("data strobe on on-chip cycle");
	a_rw_reads: assert property (acc && !(req_write_i && !req_onchip_i) |=> read_write_o [*6])
		else $error("direction low on non-write");
	a_addr_out: assert property (acc |-> ##2 (!addr_latch_strobe_n_o && muxed_addr_data_port_oe_o &&
		{high_addr_port_o, muxed_addr_data_port_o} == $past(req_addr_i, 2) &&
		prog_space_o == $past(req_program_i, 2)))
		else $error("address phase wrong");
	cover property (acc && req_write_i && !req_onchip_i);
	cover property (acc && !req_write_i);
	cover property (acc && req_onchip_i);
endmodule
bind xmbi_core xmbi_core_asserts u_asserts (.*);
`default_nettype wire

// ### tb/xmbi_mem_model.sv
// External memory with separate program and data spaces.
// Assumes the strobes and address pins of the bus master.
`default_nettype none
module xmbi_mem_model #(
	parameter logic [15:0] START_VEC = 16'h0000
) (
	input wire logic       clk_i, as_n_i, ds_n_i, rw_i, prog_i,
	input wire logic [7:0] lo_i, hi_i,
	output logic [7:0]     rd_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  mem [2][65536];
	logic [16:0] a_q;
	logic [7:0]  last_q = 8'h00;
	int          hold_q = 0;
	initial begin
		foreach (mem[s, i]) mem[s][i] = 8'h00;
		mem[1][0] = START_VEC[15:8];
		mem[1][1] = START_VEC[7:0];
	end
	assign rd_o = (!ds_n_i && rw_i) ? mem[a_q[16]][a_q[15:0]] : (hold_q > 0 ? last_q : ~last_q);
	always @(posedge clk_i) begin
		if (!as_n_i) a_q <= {prog_i, hi_i, lo_i};
		hold_q <= hold_q > 0 ? hold_q - 1 : 0;
		if (!ds_n_i && rw_i) begin
			last_q <= mem[a_q[16]][a_q[15:0]];
			hold_q <= 3;
		end
		if (!ds_n_i && !rw_i) mem[a_q[16]][a_q[15:0]] <= lo_i;
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the external memory bus master.
// Assumes xmbi_core with the memory model on its pins.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] VEC = 16'h2B4C;
	logic sys_clk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0, req_program_i = 0, req_onchip_i = 0;
	logic bus_float_i = 0;
	logic [15:0] req_addr_i = 16'h0000;
	logic [7:0] req_wdata_i = 8'h00;
	wire req_ready_o, rsp_valid_o, vec_valid_o, addr_latch_strobe_n_o, addr_latch_strobe_n_oe_o, read_write_o;
	wire xfer_timing_strobe_n_o, xfer_timing_strobe_n_oe_o, read_write_oe_o, prog_space_o, prog_space_oe_o;
	wire muxed_addr_data_port_oe_o, high_addr_port_oe_o;
	wire [7:0] rsp_rdata_o, muxed_addr_data_port_o, high_addr_port_o, mem_rd, muxed_addr_data_port_i;
	wire [15:0] vec_addr_o;
	int fail_count = 0, samples_checked = 0, n = 0;
	// Rows: write, program, on-chip, address, write data, expected response data.
	logic [34:0] rows [6] = '{{3'h6, 16'hFFFF, 8'h5A, 8'h5A}, {3'h4, 16'hFFFF, 8'hC3, 8'hC3},
		{3'h2, 16'hFFFF, 8'h00, 8'h5A}, {3'h0, 16'hFFFF, 8'h00, 8'hC3}, {3'h5, 16'h0100, 8'h99, 8'h99},
		{3'h0, 16'h0100, 8'h00, 8'h00}};
	assign muxed_addr_data_port_i = muxed_addr_data_port_oe_o ? muxed_addr_data_port_o : mem_rd;
	always #12.5 sys_clk_i = ~sys_clk_i;
	xmbi_core dut (.*);
	xmbi_mem_model #(.START_VEC(VEC)) u_mem (.clk_i(sys_clk_i), .as_n_i(addr_latch_strobe_n_o),
		.ds_n_i(xfer_timing_strobe_n_o), .rw_i(read_write_o), .prog_i(prog_space_o),
		.lo_i(muxed_addr_data_port_i), .hi_i(high_addr_port_o), .rd_o(mem_rd));
	task end_of_test;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int lim);
		@(negedge sys_clk_i);
		n++;
		if (n > lim) begin
			fail_count++;
			$display("FAIL %0t wait ran out", $time);
			end_of_test;
		end
	endtask
	task req(input logic [34:0] r);
		@(posedge sys_clk_i);
		{req_write_i, req_program_i, req_onchip_i, req_addr_i, req_wdata_i} <= r[34:8];
		req_valid_i <= 1;
		n = 0;
		do tick(50); while (req_ready_o !== 1);
		@(posedge sys_clk_i);
		req_valid_i <= 0;
		n = 0;
		do tick(50); while (rsp_valid_o !== 1);
		chk(n[15:0], 16'd7);
		chk({8'h00, rsp_rdata_o}, {8'h00, r[7:0]});
	endtask
	task reset_run;
		sys_rst_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		chk({addr_latch_strobe_n_o, xfer_timing_strobe_n_o, read_write_o, req_ready_o}, 16'hE);
		sys_rst_i <= 0;
		n = 0;
		do tick(100); while (vec_valid_o !== 1);
		chk(vec_addr_o, VEC);
	endtask
	initial begin
		reset_run;
		foreach (rows[i]) req(rows[i]);
		@(posedge sys_clk_i);
		bus_float_i <= 1;
		repeat (2) @(negedge sys_clk_i);
		chk({addr_latch_strobe_n_oe_o, xfer_timing_strobe_n_oe_o, read_write_oe_o, prog_space_oe_o,
			high_addr_port_oe_o, muxed_addr_data_port_oe_o, req_ready_o}, 16'h0);
		@(posedge sys_clk_i);
		bus_float_i <= 0;
		reset_run;
		req(rows[3]);
		end_of_test;
	end
endmodule
`default_nettype wire
